// file: src/mode_bits_consts.vh
`ifndef MODE_BITS_CONSTS_VH
`define MODE_BITS_CONSTS_VH
// field positions of status_one_mode_bits
`define FRAC_BIT 6
`define WIDE_BIT 10
`define IRQ_DIS_BIT 11
`define HOLD_STOP_BIT 12
// reset values
`define FRAC_RST 1'b0
`define WIDE_RST 1'b0
`define IRQ_DIS_RST 1'b1
`define HOLD_STOP_RST 1'b0
`define STATUS_RST 16'h0800
// mask of bits held by this block
`define ST1_OWN_MASK 16'h1C40
// accumulator limits
`define SAT32_POS 40'h00_7FFF_FFFF
`define SAT32_NEG 40'hFF_8000_0000
`define SAT40_POS 40'h7F_FFFF_FFFF
`define SAT40_NEG 40'h80_0000_0000
// bit-instruction field selects
`define SEL_FRAC 2'h0
`define SEL_HOLD_STOP 2'h1
`define SEL_IRQ_DIS 2'h2
`define SEL_WIDE 2'h3
// legacy unprotected window, in instructions
`define LEGACY_WINDOW 3'h5
`endif

// file: src/acc_mode_unit.v
`include "mode_bits_consts.vh"
// d-unit accumulator arithmetic in 32- or 40-bit mode
module acc_mode_unit #(
   parameter W = 40
) (
   // mode
   input wire wide_i,
   input wire sat_en_i,
   // operands
   input wire [W-1:0] a_i,
   input wire [W-1:0] b_i,
   input wire shift_left_i,
   input wire rotate_i,
   input wire rot_in_i,
   // results
   output reg [W-1:0] sum_o,
   output reg carry_o,
   output reg ovf_o,
   output reg sign_o,
   output reg zero_o,
   output reg [W-1:0] shift_o,
   output reg shift_out_o
);
   reg [W:0] full;
   reg s_a;
   reg s_b;
   reg s_r;
   always @* begin
      full = {1'b0, a_i} + {1'b0, b_i};
      s_a = wide_i ? a_i[39] : a_i[31];
      s_b = wide_i ? b_i[39] : b_i[31];
      s_r = wide_i ? full[39] : full[31];
      sign_o = s_a;
      carry_o = wide_i ? full[40] : (a_i[32] ^ b_i[32] ^ full[32]);
      ovf_o = (s_a == s_b) && (s_r != s_a);
      sum_o = full[W-1:0];
      if (sat_en_i && ovf_o) begin
         if (wide_i) begin
            sum_o = s_a ? `SAT40_NEG : `SAT40_POS;
         end else begin
            sum_o = s_a ? `SAT32_NEG : `SAT32_POS;
         end
      end
      zero_o = wide_i ? (a_i == {W{1'b0}}) : (a_i[31:0] == 32'h0000_0000);
      shift_o = a_i;
      if (wide_i) begin
         if (shift_left_i) begin
            shift_out_o = a_i[39];
            shift_o = {a_i[38:0], rotate_i ? rot_in_i : 1'b0};
         end else begin
            shift_out_o = a_i[0];
            shift_o = {rotate_i ? rot_in_i : a_i[39], a_i[39:1]};
         end
      end else begin
         if (shift_left_i) begin
            shift_out_o = a_i[31];
            shift_o = {8'h00, a_i[30:0], rotate_i ? rot_in_i : 1'b0};
         end else begin
            shift_out_o = a_i[0];
            shift_o = {8'h00, rotate_i ? rot_in_i : a_i[31], a_i[31:1]};
         end
      end
   end
endmodule // acc_mode_unit

// file: src/mode_status_bits.v
// Behaviour
// - fractional shift at bit 6, reset 0; clear means products pass unshifted
// - fractional shift set shifts every product left by one bit
// - hold stop at bit 12, reset 0; hold request floats external port outputs
// - during granted hold, hold stop 1 stops internal execution, 0 continues
// - irq disable at bit 11, reset 1; blocks maskable interrupts when set
// - nonmaskable interrupts pass regardless of irq disable
// - bit instructions, whole-register write, return-from-interrupt and interrupt entry change irq disable
// - new cores: no maskable interrupt accepted once disable-setting instruction issued
// - old cores: interrupt may still be taken within five following instructions
// - accepted interrupt saves whole status register to data stack
// - software interrupt, software reset, hardware interrupt set disable before entry
// - trap leaves irq disable unchanged
// - return-from-interrupt restores irq disable from saved stack value
// - debug halt ignores irq disable, services only time-critical and nonmaskable interrupts
// - wide mode at bit 10, read/write, reset 0, selects computation mode
// - 32-bit mode: sign, carry, overflow at bit 31
// - 32-bit saturation to 00_7fff_ffff or ff_8000_0000
// - 32-bit zero compare uses bits 31..0
// - 32-bit shifts act on bit 31 boundary
// - 40-bit mode uses bit 39 and saturates to 7f_ffff_ffff or 80_0000_0000
`include "mode_bits_consts.vh"
module mode_status_bits #(
   parameter NEW_CORE = 1,
   parameter PROD_W = 32,
   parameter ACC_W = 40
) (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_n_i,
   // bit set/clear instructions
   input wire bit_set_instr_i,
   input wire bit_clear_instr_i,
   input wire [1:0] bit_sel_i,
   // whole-register write and read
   input wire st1_wr_i,
   input wire [15:0] st1_wdata_i,
   output wire [15:0] status_one_mode_bits_o,
   // instruction stream
   input wire instr_issue_i,
   input wire instr_exec_i,
   input wire software_interrupt_instr_i,
   input wire software_reset_instr_i,
   input wire trap_instr_i,
   input wire reti_instr_i,
   input wire [15:0] stack_st1_i,
   // interrupt sources
   input wire maskable_irq_i,
   input wire nonmaskable_irq_i,
   input wire time_critical_irq_i,
   input wire debug_halt_i,
   output wire irq_take_o,
   output reg stack_push_o,
   output reg [15:0] stack_st1_o,
   // hold from external requester
   input wire hold_req_i,
   output wire hold_ack_o,
   output wire external_memory_port_oe_o,
   output wire exec_stall_o,
   // multiplier path
   input wire [PROD_W-1:0] product_i,
   output reg [PROD_W-1:0] product_o,
   // accumulator path
   input wire sat_en_i,
   input wire [ACC_W-1:0] acc_a_i,
   input wire [ACC_W-1:0] acc_b_i,
   input wire shift_left_i,
   input wire rotate_i,
   input wire rot_in_i,
   output reg [ACC_W-1:0] acc_sum_o,
   output reg acc_carry_o,
   output reg acc_ovf_o,
   output reg acc_sign_o,
   output reg acc_zero_o,
   output reg [ACC_W-1:0] acc_shift_o,
   output reg acc_shift_out_o
);
   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   reg hold_s1_r;
   reg hold_s2_r;
   reg [2:0] irq_s1_r;
   reg [2:0] irq_s2_r;
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         hold_s1_r <= 1'b0;
         hold_s2_r <= 1'b0;
         irq_s1_r <= 3'h0;
         irq_s2_r <= 3'h0;
      end else begin
         hold_s1_r <= hold_req_i;
         hold_s2_r <= hold_s1_r;
         irq_s1_r <= {time_critical_irq_i, nonmaskable_irq_i, maskable_irq_i};
         irq_s2_r <= irq_s1_r;
      end
   end
   wire mask_irq = irq_s2_r[0];
   wire nmi_irq = irq_s2_r[1];
   wire tc_irq = irq_s2_r[2];
   ////////////////////////////////////////////////////////////////
   // mode bits
   reg frac_r;
   reg hold_stop_r;
   reg irq_dis_r;
   reg wide_r;
   reg frac_nxt;
   reg hold_stop_nxt;
   reg irq_dis_nxt;
   reg wide_nxt;
   reg [2:0] legacy_cnt_r;
   reg [2:0] legacy_cnt_nxt;
   reg dis_pend_r;
   reg dis_pend_nxt;
   wire bit_op = bit_set_instr_i || bit_clear_instr_i;
   wire dis_set_op = bit_set_instr_i && (bit_sel_i == `SEL_IRQ_DIS);
   wire dis_clr_op = bit_clear_instr_i && (bit_sel_i == `SEL_IRQ_DIS);
   wire sw_entry = software_interrupt_instr_i || software_reset_instr_i;
   ////////////////////////////////////////////////////////////////
   // interrupt acceptance
   // effective disable as seen by interrupt acceptance
   wire dis_eff = (NEW_CORE != 0) ? (irq_dis_r || dis_set_op) : irq_dis_r;
   wire mask_ok = !debug_halt_i && mask_irq && !dis_eff;
   wire dbg_ok = debug_halt_i && tc_irq;
   wire hw_take = mask_ok || nmi_irq || dbg_ok;
   wire entry = hw_take || sw_entry;
   assign irq_take_o = hw_take;
   assign status_one_mode_bits_o = {3'h0, hold_stop_r, irq_dis_r, wide_r, 3'h0, frac_r, 6'h00};
   ////////////////////////////////////////////////////////////////
   // fractional-shift field
   always @* begin
      frac_nxt = frac_r;
      if (st1_wr_i) begin
         frac_nxt = st1_wdata_i[`FRAC_BIT];
      end
      if (bit_op && (bit_sel_i == `SEL_FRAC)) begin
         frac_nxt = bit_set_instr_i;
      end
   end
   ////////////////////////////////////////////////////////////////
   // hold-stop field
   always @* begin
      hold_stop_nxt = hold_stop_r;
      if (st1_wr_i) begin
         hold_stop_nxt = st1_wdata_i[`HOLD_STOP_BIT];
      end
      if (bit_op && (bit_sel_i == `SEL_HOLD_STOP)) begin
         hold_stop_nxt = bit_set_instr_i;
      end
   end
   ////////////////////////////////////////////////////////////////
   // wide-accumulator field
   always @* begin
      wide_nxt = wide_r;
      if (st1_wr_i) begin
         wide_nxt = st1_wdata_i[`WIDE_BIT];
      end
      if (bit_op && (bit_sel_i == `SEL_WIDE)) begin
         wide_nxt = bit_set_instr_i;
      end
   end
   ////////////////////////////////////////////////////////////////
   // interrupt-disable field, lowest priority first
   always @* begin
      irq_dis_nxt = irq_dis_r;
      if (st1_wr_i) begin
         irq_dis_nxt = st1_wdata_i[`IRQ_DIS_BIT];
      end
      if (dis_set_op && (NEW_CORE != 0)) begin
         irq_dis_nxt = 1'b1;
      end
      if (dis_clr_op) begin
         irq_dis_nxt = 1'b0;
      end
      // old cores: the set lands after the execute-stage delay
      if (dis_pend_r && instr_exec_i && (legacy_cnt_r <= 3'h1)) begin
         irq_dis_nxt = 1'b1;
      end
      if (reti_instr_i) begin
         irq_dis_nxt = stack_st1_i[`IRQ_DIS_BIT];
      end
      // trap does not touch the disable field
      if (entry) begin
         irq_dis_nxt = 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////
   // old-core pending window
   always @* begin
      dis_pend_nxt = dis_pend_r;
      legacy_cnt_nxt = legacy_cnt_r;
      if (dis_set_op && (NEW_CORE == 0)) begin
         dis_pend_nxt = 1'b1;
         legacy_cnt_nxt = `LEGACY_WINDOW;
      end
      if (dis_pend_r && instr_exec_i) begin
         if (legacy_cnt_r <= 3'h1) begin
            dis_pend_nxt = 1'b0;
            legacy_cnt_nxt = 3'h0;
         end else begin
            legacy_cnt_nxt = legacy_cnt_r - 3'h1;
         end
      end
      if (entry) begin
         dis_pend_nxt = 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////
   // field registers
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         frac_r <= `FRAC_RST;
      end else begin
         frac_r <= frac_nxt;
      end
   end
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         hold_stop_r <= `HOLD_STOP_RST;
      end else begin
         hold_stop_r <= hold_stop_nxt;
      end
   end
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         irq_dis_r <= `IRQ_DIS_RST;
      end else begin
         irq_dis_r <= irq_dis_nxt;
      end
   end
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wide_r <= `WIDE_RST;
      end else begin
         wide_r <= wide_nxt;
      end
   end
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         legacy_cnt_r <= 3'h0;
         dis_pend_r <= 1'b0;
      end else begin
         legacy_cnt_r <= legacy_cnt_nxt;
         dis_pend_r <= dis_pend_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////
   // status save on entry and trap
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         stack_push_o <= 1'b0;
         stack_st1_o <= 16'h0000;
      end else begin
         stack_push_o <= entry || trap_instr_i;
         if (entry || trap_instr_i) begin
            stack_st1_o <= status_one_mode_bits_o;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // hold handling
   assign hold_ack_o = hold_s2_r;
   assign external_memory_port_oe_o = !hold_s2_r;
   assign exec_stall_o = hold_s2_r && hold_stop_r;
   ////////////////////////////////////////////////////////////////
   // multiplier result
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         product_o <= {PROD_W{1'b0}};
      end else if (frac_r) begin
         product_o <= {product_i[PROD_W-2:0], 1'b0};
      end else begin
         product_o <= product_i;
      end
   end
   ////////////////////////////////////////////////////////////////
   // accumulator unit
   wire [ACC_W-1:0] sum_w;
   wire [ACC_W-1:0] shift_w;
   wire carry_w;
   wire ovf_w;
   wire sign_w;
   wire zero_w;
   wire shout_w;
   acc_mode_unit #(
      .W(ACC_W)
   ) u_acc (
      .wide_i(wide_r),
      .sat_en_i(sat_en_i),
      .a_i(acc_a_i),
      .b_i(acc_b_i),
      .shift_left_i(shift_left_i),
      .rotate_i(rotate_i),
      .rot_in_i(rot_in_i),
      .sum_o(sum_w),
      .carry_o(carry_w),
      .ovf_o(ovf_w),
      .sign_o(sign_w),
      .zero_o(zero_w),
      .shift_o(shift_w),
      .shift_out_o(shout_w)
   );
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         acc_sum_o <= {ACC_W{1'b0}};
         acc_carry_o <= 1'b0;
         acc_ovf_o <= 1'b0;
         acc_sign_o <= 1'b0;
         acc_zero_o <= 1'b0;
         acc_shift_o <= {ACC_W{1'b0}};
         acc_shift_out_o <= 1'b0;
      end else begin
         acc_sum_o <= sum_w;
         acc_carry_o <= carry_w;
         acc_ovf_o <= ovf_w;
         acc_sign_o <= sign_w;
         acc_zero_o <= zero_w;
         acc_shift_o <= shift_w;
         acc_shift_out_o <= shout_w;
      end
   end
endmodule // mode_status_bits

// file: test/mode_status_bits_props.sv
module mode_bits_checker (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_n_i,
   // status access
   input wire bit_set_instr_i,
   input wire bit_clear_instr_i,
   input wire [1:0] bit_sel_i,
   input wire st1_wr_i,
   input wire [15:0] status_one_mode_bits_o,
   // instructions and interrupts
   input wire trap_instr_i,
   input wire reti_instr_i,
   input wire [15:0] stack_st1_i,
   input wire nonmaskable_irq_i,
   input wire debug_halt_i,
   input wire irq_take_o,
   input wire stack_push_o,
   input wire [15:0] stack_st1_o,
   // hold and product
   input wire hold_req_i,
   input wire external_memory_port_oe_o,
   input wire exec_stall_o,
   input wire [31:0] product_i,
   input wire [31:0] product_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [15:0] st = status_one_mode_bits_o;
   wire [3:0] bi = bit_sel_i == 2'h0 ? 4'h6 : bit_sel_i == 2'h1 ? 4'hC : {3'h5, ~bit_sel_i[0]};
   wire quiet = !(st1_wr_i | reti_instr_i);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_hold_seen;
      hold_req_i [*3];
   endsequence
   sequence s_entry;
      stack_push_o && st[11] && stack_st1_o == $past(st);
   endsequence
   property p_reset_val;
      $rose(rst_n_i) |-> st == 16'h0800;
   endproperty
   property p_fractional_shift_enable_off;
      !st[6] |=> product_o == $past(product_i);
   endproperty
   property p_fractional_shift_enable_on;
      st[6] |=> product_o == {$past(product_i[30:0]), 1'b0};
   endproperty
   property p_hold_float;
      s_hold_seen |-> !external_memory_port_oe_o;
   endproperty
   property p_hold_stop;
      exec_stall_o == (!external_memory_port_oe_o && st[12]);
   endproperty
   property p_bit_set;
      bit_set_instr_i && quiet |=> st[$past(bi)];
   endproperty
   property p_bit_only;
      (bit_set_instr_i | bit_clear_instr_i) && quiet
         |=> ((st ^ $past(st)) & ~(16'h0001 << $past(bi)) & 16'hF7FF) == 16'h0000;
   endproperty
   property p_nmi;
      $rose(nonmaskable_irq_i) && !debug_halt_i |-> ##[1:4] irq_take_o;
   endproperty
   property p_entry;
      irq_take_o |=> s_entry;
   endproperty
   property p_trap;
      trap_instr_i && !irq_take_o && !bit_set_instr_i && !bit_clear_instr_i && quiet
         |=> st[11] == $past(st[11]);
   endproperty
   property p_reti;
      reti_instr_i && !irq_take_o |=> st[11] == $past(stack_st1_i[11]);
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("status reset value wrong");
   a_fractional_shift_enable_off: assert property (p_fractional_shift_enable_off) else $error("product shifted");
   a_fractional_shift_enable_on: assert property (p_fractional_shift_enable_on) else $error("product not shifted");
   a_hold_float: assert property (p_hold_float) else $error("port not floated");
   a_hold_stop: assert property (p_hold_stop) else $error("stall wrong");
   a_bit_set: assert property (p_bit_set) else $error("bit set lost");
   a_bit_only: assert property (p_bit_only) else $error("other bits changed");
   a_nmi: assert property (p_nmi) else $error("nmi not taken");
   a_entry: assert property (p_entry) else $error("entry save wrong");
   a_trap: assert property (p_trap) else $error("trap changed disable");
   a_reti: assert property (p_reti) else $error("reti restore wrong");
endmodule // mode_bits_checker
bind mode_status_bits mode_bits_checker u_props (.*);

// file: test/hold_irq_model.sv
module hold_irq_model (
   // clock
   input wire clk_sys_i,
   // wanted levels: hold, maskable, nonmaskable, time-critical
   input wire [3:0] want_i,
   output logic [3:0] line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 32'h1576;
   initial line_o = 4'h0;
   // lines follow the wish after a random delay, off the edge
   always @(posedge clk_sys_i) begin
      #3;
      for (int k = 0; k < 4; k++)
         if (($random(seed) & 1) == 1) line_o[k] = want_i[k];
   end
endmodule // hold_irq_model

// file: test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 0, rst_n_i = 0, bit_set_instr = 0, bit_clear_instr = 0, wr = 0, sat = 0, shl = 0, dbg = 0;
   logic [1:0] sel = 0;
   logic [3:0] ins = 0, want = 0, k;
   logic [15:0] wdata = 0, stk = 0, exp_st = 16'h0800;
   logic [31:0] prod = 0;
   logic [39:0] a = 0, b = 0;
   logic [41:0] e;
   wire [3:0] line;
   wire [15:0] st, stk_o;
   wire take, push, ack, oe, stall, cy, ov, sg, zr, sho;
   wire [31:0] prod_o;
   wire [39:0] sum, shv;
   integer mismatches = 0, total_checks = 0, seed = 32'h1576, takes = 0, tk;
   initial forever #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (take === 1'b1) takes++;
   hold_irq_model u_src (.clk_sys_i(clk_sys_i), .want_i(want), .line_o(line));
   mode_status_bits #(.NEW_CORE(1)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .bit_set_instr_i(bit_set_instr), .bit_clear_instr_i(bit_clear_instr), .bit_sel_i(sel), .st1_wr_i(wr),
      .st1_wdata_i(wdata), .status_one_mode_bits_o(st), .instr_issue_i(1'b0),
      .instr_exec_i(1'b0), .software_interrupt_instr_i(ins[0]),
      .software_reset_instr_i(ins[1]), .trap_instr_i(ins[2]), .reti_instr_i(ins[3]),
      .stack_st1_i(stk), .maskable_irq_i(line[1]), .nonmaskable_irq_i(line[2]),
      .time_critical_irq_i(line[3]), .debug_halt_i(dbg), .irq_take_o(take),
      .stack_push_o(push), .stack_st1_o(stk_o), .hold_req_i(line[0]), .hold_ack_o(ack),
      .external_memory_port_oe_o(oe), .exec_stall_o(stall), .product_i(prod),
      .product_o(prod_o), .sat_en_i(sat), .acc_a_i(a), .acc_b_i(b), .shift_left_i(shl),
      .rotate_i(1'b0), .rot_in_i(1'b0), .acc_sum_o(sum), .acc_carry_o(cy), .acc_ovf_o(ov),
      .acc_sign_o(sg), .acc_zero_o(zr), .acc_shift_o(shv), .acc_shift_out_o(sho));
   function automatic logic [41:0] acc_exp(logic w, logic [39:0] x, logic [39:0] y);
      logic [40:0] t;
      logic [32:0] c;
      t = x + y;
      c = x[31:0] + y[31:0];
      if (w) return {t[40], x[39] == y[39] && t[39] != x[39],
         x[39] ? 40'h80_0000_0000 : 40'h7F_FFFF_FFFF};
      return {c[32], x[31] == y[31] && t[31] != x[31],
         x[31] ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF};
   endfunction
   function automatic logic [39:0] shift_exp(logic w, logic l, logic [39:0] x);
      if (l) return w ? {x[38:0], 1'b0} : {8'h00, x[30:0], 1'b0};
      return w ? {x[39], x[39:1]} : {8'h00, x[31], x[31:1]};
   endfunction
   task automatic chk(string n, logic [39:0] s, logic [39:0] x);
      total_checks++;
      if (s !== x) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic bop(logic s, logic [1:0] f);
      bit_set_instr = s;
      bit_clear_instr = !s;
      sel = f;
      exp_st[f == 0 ? 6 : f == 1 ? 12 : f == 2 ? 11 : 10] = s;
      @(negedge clk_sys_i);
      bit_set_instr = 0;
      bit_clear_instr = 0;
      @(negedge clk_sys_i);
   endtask
   task automatic do_ins(logic [3:0] v);
      ins = v;
      @(negedge clk_sys_i);
      ins = 0;
      @(negedge clk_sys_i);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      wrap_up;
   end
   initial begin
      repeat (16) @(negedge clk_sys_i);
      rst_n_i = 1;
      chk("reset status", st, 16'h0800);
      for (int i = 0; i < 2; i++) begin
         wdata = i ? 16'h0000 : 16'hFFFF;
         wr = 1;
         @(negedge clk_sys_i);
         wr = 0;
         chk("whole write", st, wdata & 16'h1C40);
      end
      exp_st = 0;
      for (int i = 0; i < 40; i++) begin
         k = $random(seed);
         bop(k[0], k[2:1]);
         chk("status bits", st, exp_st);
      end
      for (int i = 0; i < 30; i++) begin
         bop(i[0], 2'h0);
         prod = i < 2 ? 32'hC000_0001 : $random(seed);
         @(negedge clk_sys_i);
         chk("product", prod_o, i[0] ? {prod[30:0], 1'b0} : prod);
      end
      for (int h = 0; h < 2; h++) begin
         bop(h[0], 2'h1);
         want[0] = 1;
         repeat (20) if (oe === 1'b1) @(negedge clk_sys_i);
         chk("port enable held", oe, 0);
         chk("exec stall", stall, h[0]);
         chk("hold ack", ack, 1);
         want[0] = 0;
         repeat (20) if (oe !== 1'b1) @(negedge clk_sys_i);
      end
      bop(1, 2'h2);
      tk = takes;
      want[1] = 1;
      repeat (12) @(negedge clk_sys_i);
      chk("masked takes", takes - tk, 0);
      bop(0, 2'h2);
      repeat (20) if (takes == tk) @(negedge clk_sys_i);
      chk("entry disable", st[11], 1);
      chk("saved disable", stk_o[11], 0);
      want[1] = 0;
      repeat (20) if (line[1]) @(negedge clk_sys_i);
      tk = takes;
      want[2] = 1;
      repeat (10) @(negedge clk_sys_i);
      want[2] = 0;
      chk("nmi taken", takes > tk, 1);
      repeat (20) if (line[2]) @(negedge clk_sys_i);
      repeat (3) @(negedge clk_sys_i);
      for (int i = 0; i < 2; i++) begin
         stk = st & 16'hF7FF;
         do_ins(4'h8);
         chk("reti restore", st[11], 0);
         do_ins(4'h4);
         chk("trap keeps", st[11], 0);
         do_ins(i ? 4'h2 : 4'h1);
         chk("sw entry sets", st[11], 1);
      end
      dbg = 1;
      bop(0, 2'h2);
      tk = takes;
      want[1] = 1;
      repeat (12) @(negedge clk_sys_i);
      chk("halted masked takes", takes - tk, 0);
      want[3] = 1;
      repeat (20) if (takes == tk) @(negedge clk_sys_i);
      chk("time-critical taken", takes > tk, 1);
      want = 0;
      repeat (20) if (line[1] | line[3]) @(negedge clk_sys_i);
      repeat (3) @(negedge clk_sys_i);
      dbg = 0;
      for (int w = 0; w < 2; w++) begin
         bop(w[0], 2'h3);
         for (int i = 0; i < 30; i++) begin
            a = i == 0 ? 40'h00_7FFF_FFFF : i < 3 ? {i[0], 39'h0} - 1 :
               i == 3 ? 40'hFF_0000_0000 : {$random(seed), $random(seed)};
            b = i == 0 ? 1 : i < 3 ? a : {$random(seed), $random(seed)};
            sat = i < 3 || $random(seed);
            shl = $random(seed);
            e = acc_exp(w[0], a, b);
            @(negedge clk_sys_i);
            chk("carry", cy, e[41]);
            chk("overflow", ov, e[40]);
            if (sat && e[40]) chk("saturated sum", sum, e[39:0]);
            else chk("sum", sum, a + b);
            chk("sign", sg, w[0] ? a[39] : a[31]);
            chk("zero", zr, w[0] ? a == 0 : a[31:0] == 0);
            chk("shift out", sho, shl ? (w[0] ? a[39] : a[31]) : a[0]);
            chk("shift value", shv, shift_exp(w[0], shl, a));
         end
      end
      wrap_up;
   end
endmodule // testbench
